// file: core/instruction_word_decode_timing_defs.vh
// Opcodes, field positions and cycle counts for the instruction word decoder
`ifndef INSTRUCTION_WORD_DECODE_TIMING_DEFS_VH
`define INSTRUCTION_WORD_DECODE_TIMING_DEFS_VH

// Word layout
`define WORD_W          24
`define OPC_LSB         16
`define OPC_W           8

// Opcodes (control range)
`define NOP_OP               8'h00
`define INDIRECT_OP          8'h01
`define DW_CALL_OP           8'h02
`define DW_GOTO_OP           8'h04
`define DW_MOVE_OP           8'h08
`define RETURN_OP            8'h06
`define INTERRUPT_RETURN_OP  8'h07
`define TABLE_READ_OP        8'h0A
`define TABLE_WRITE_OP       8'h0B
`define JUMP_RELATIVE_OP     8'h37

// Opcode ranges (upper nibble or upper three bits)
`define COND_BRANCH_NIB 4'h3
`define THREE_OP_TOP    3'h2
`define LIT_ARITH_NIB   4'h6
`define LIT_MOVE_NIB    4'h7
`define BIT_NIB         4'hA
`define FILE_NIB        4'hB

// Three-operand form
`define F3_BASE_LSB     14
`define F3_DMOD_LSB     11
`define F3_DEST_LSB     7
`define F3_SMOD_LSB     4
`define F3_SRC_LSB      0
// Literal arithmetic form
`define FL_BASE_LSB     12
`define FL_DEST_LSB     8
`define FL_DMOD_LSB     5
`define FL_LIT_LSB      0
// Literal move form
`define FM_LIT_LSB      4
`define FM_DEST_LSB     0
// File form
`define FF_ADDR_LSB     0
`define FF_ACC_BIT      1
`define FF_BYTE_BIT     0
// Bit form
`define FB_REGSEL_BIT   3
`define FB_POS_LSB      12
`define FB_BASE_LSB     8
`define FB_SMOD_LSB     4
`define FB_SRC_LSB      0

// Groups, one-hot
`define GRP_WORD_BYTE   4'h1
`define GRP_BIT         4'h2
`define GRP_LITERAL     4'h4
`define GRP_CONTROL     4'h8

// Extra NOP cycles after the execute cycle, total cycle counts, direct modifier
`define EXTRA_NONE      2'h0
`define EXTRA_COND      2'h1
`define EXTRA_BRANCH    2'h1
`define EXTRA_TABLE     2'h1
`define EXTRA_RETURN    2'h2
`define CYC_ONE         2'h1
`define CYC_TWO         2'h2
`define CYC_THREE       2'h3
`define MOD_DIRECT      3'h0

`endif

// file: core/instruction_word_decode_timing.v
// Instruction word format recognition and cycle-count control
`timescale 1ns/100ps
`include "instruction_word_decode_timing_defs.vh"

// Notes on behaviour
// - 24-bit word, 8-bit opcode, operand fields follow
// - Exactly three opcodes take two words
// - 48 bits; second word top byte zero
// - Lone second word executes as NOP
// - One cycle; taken condition adds NOP cycle
// - Branch, indirect, table, returns take 2-3
// - Taken skip costs 2 or 3 cycles
// - Double-word instructions take exactly two cycles
// - Four groups: word/byte, bit, literal, control
// - Three-operand form: base, source, destination
// - File form: address plus destination selector
// - Bit position from literal or base register
// - Literal arithmetic: destination only when different
module instruction_word_decode_timing (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        fetch_valid,
    input  wire [23:0] fetch_word,
    input  wire        cond_true,
    output wire        fetch_ready,
    output reg         exec_valid_r,
    output reg         is_nop_r,
    output reg         skipped_r,
    output reg         illegal_r,
    output reg         double_word_r,
    output reg         dword_error_r,
    output reg  [1:0]  cycles_r,
    output reg  [7:0]  op_code_r,
    output reg  [3:0]  group_r,
    output reg  [3:0]  base_source_reg_r,
    output reg  [3:0]  second_source_reg_r,
    output reg  [2:0]  second_mod_r,
    output reg  [3:0]  result_dest_reg_r,
    output reg  [2:0]  dest_mod_r,
    output reg         has_dest_r,
    output reg  [12:0] file_addr_r,
    output reg         dest_to_acc_r,
    output reg         byte_mode_r,
    output reg  [3:0]  bit_pos_r,
    output reg         bit_from_reg_r,
    output reg  [15:0] literal_r
);

    localparam [4:0] ST_FIRST  = 5'b00001;
    localparam [4:0] ST_SECOND = 5'b00010;
    localparam [4:0] ST_NOP    = 5'b00100;
    localparam [4:0] ST_SKIP   = 5'b01000;
    localparam [4:0] ST_SKIP2  = 5'b10000;

    function is_dword;
        input [7:0] op;
        begin
            is_dword = (op == `DW_CALL_OP) || (op == `DW_GOTO_OP) ||
                       (op == `DW_MOVE_OP);
        end
    endfunction

    function [3:0] op_group;
        input [7:0] op;
        begin
            if (op[7:5] == `THREE_OP_TOP || op[7:4] == `FILE_NIB || op == `DW_MOVE_OP)
                op_group = `GRP_WORD_BYTE;
            else if (op[7:4] == `BIT_NIB)
                op_group = `GRP_BIT;
            else if (op[7:4] == `LIT_ARITH_NIB || op[7:4] == `LIT_MOVE_NIB)
                op_group = `GRP_LITERAL;
            else
                op_group = `GRP_CONTROL;
        end
    endfunction

    function [1:0] extra_cycles;
        input [7:0] op;
        input       cond;
        begin
            if (op == `JUMP_RELATIVE_OP)
                extra_cycles = `EXTRA_BRANCH;
            else if (op[7:4] == `COND_BRANCH_NIB)
                extra_cycles = cond ? `EXTRA_COND : `EXTRA_NONE;
            else if (op == `INDIRECT_OP)
                extra_cycles = `EXTRA_BRANCH;
            else if (op == `TABLE_READ_OP || op == `TABLE_WRITE_OP)
                extra_cycles = `EXTRA_TABLE;
            else if (op == `RETURN_OP || op == `INTERRUPT_RETURN_OP)
                extra_cycles = `EXTRA_RETURN;
            else
                extra_cycles = `EXTRA_NONE;
        end
    endfunction

    reg  [4:0]  state_r;
    reg  [1:0]  nop_cnt_r;
    reg  [23:0] first_word_r;

    // One decoder serves both the live word and a held first word
    wire [23:0] dec_word = (state_r == ST_SECOND) ? first_word_r : fetch_word;
    wire [7:0]  dec_op   = dec_word[`OPC_LSB +: `OPC_W];
    wire [7:0]  fetch_op = fetch_word[`OPC_LSB +: `OPC_W];
    wire [1:0]  extra    = extra_cycles(fetch_op, cond_true);
    wire        is_skip  = (fetch_op[7:4] == `BIT_NIB) && (fetch_op[2:1] == 2'h3);

    reg  [3:0]  base_nxt;
    reg  [3:0]  src_nxt;
    reg  [2:0]  smod_nxt;
    reg  [3:0]  dest_nxt;
    reg  [2:0]  dmod_nxt;
    reg         has_dest_nxt;
    reg  [12:0] faddr_nxt;
    reg         acc_nxt;
    reg         byte_nxt;
    reg  [3:0]  bpos_nxt;
    reg         bsel_nxt;
    reg  [15:0] lit_nxt;
    reg         illegal_nxt;

    always @* begin
        base_nxt     = 4'h0;
        src_nxt      = 4'h0;
        smod_nxt     = `MOD_DIRECT;
        dest_nxt     = 4'h0;
        dmod_nxt     = `MOD_DIRECT;
        has_dest_nxt = 1'b0;
        faddr_nxt    = 13'h0000;
        acc_nxt      = 1'b0;
        byte_nxt     = 1'b0;
        bpos_nxt     = 4'h0;
        bsel_nxt     = 1'b0;
        lit_nxt      = 16'h0000;
        illegal_nxt  = 1'b0;
        if (dec_op[7:5] == `THREE_OP_TOP) begin
            // Base register borrows two opcode bits, it has no modifier
            base_nxt     = {dec_op[1:0], dec_word[`F3_BASE_LSB +: 2]};
            dmod_nxt     = dec_word[`F3_DMOD_LSB +: 3];
            dest_nxt     = dec_word[`F3_DEST_LSB +: 4];
            smod_nxt     = dec_word[`F3_SMOD_LSB +: 3];
            src_nxt      = dec_word[`F3_SRC_LSB +: 4];
            has_dest_nxt = 1'b1;
        end else if (dec_op[7:4] == `LIT_ARITH_NIB) begin
            base_nxt     = dec_word[`FL_BASE_LSB +: 4];
            lit_nxt      = {11'h000, dec_word[`FL_LIT_LSB +: 5]};
            dest_nxt     = dec_word[`FL_DEST_LSB +: 4];
            dmod_nxt     = dec_word[`FL_DMOD_LSB +: 3];
            has_dest_nxt = !((dest_nxt == base_nxt) && (dmod_nxt == `MOD_DIRECT));
        end else if (dec_op[7:4] == `LIT_MOVE_NIB) begin
            lit_nxt      = {dec_op[3:0], dec_word[`FM_LIT_LSB +: 12]};
            dest_nxt     = dec_word[`FM_DEST_LSB +: 4];
            has_dest_nxt = 1'b1;
        end else if (dec_op[7:4] == `FILE_NIB) begin
            faddr_nxt    = dec_word[`FF_ADDR_LSB +: 13];
            acc_nxt      = dec_op[`FF_ACC_BIT];
            byte_nxt     = dec_op[`FF_BYTE_BIT];
            has_dest_nxt = 1'b1;
        end else if (dec_op[7:4] == `BIT_NIB) begin
            bsel_nxt     = dec_op[`FB_REGSEL_BIT];
            bpos_nxt     = dec_word[`FB_POS_LSB +: 4];
            base_nxt     = dec_word[`FB_BASE_LSB +: 4];
            smod_nxt     = dec_word[`FB_SMOD_LSB +: 3];
            src_nxt      = dec_word[`FB_SRC_LSB +: 4];
        end else if (dec_op[7:4] == `COND_BRANCH_NIB) begin
            lit_nxt      = dec_word[15:0];
        end else if (dec_op == `DW_MOVE_OP) begin
            faddr_nxt    = dec_word[`FF_ADDR_LSB +: 13];
        end else if (dec_op[7:4] != 4'h0) begin
            illegal_nxt  = 1'b1;
        end
    end

    // Stall fetch while inserted NOP cycles run
    assign fetch_ready = (state_r != ST_NOP);

    always @(posedge clk_sys) begin
        if (rst) begin
            state_r             <= ST_FIRST;
            nop_cnt_r           <= 2'h0;
            first_word_r        <= 24'h00_0000;
            exec_valid_r        <= 1'b0;
            is_nop_r            <= 1'b0;
            skipped_r           <= 1'b0;
            illegal_r           <= 1'b0;
            double_word_r       <= 1'b0;
            dword_error_r       <= 1'b0;
            cycles_r            <= 2'h0;
            op_code_r           <= 8'h00;
            group_r             <= 4'h0;
            base_source_reg_r   <= 4'h0;
            second_source_reg_r <= 4'h0;
            second_mod_r        <= 3'h0;
            result_dest_reg_r   <= 4'h0;
            dest_mod_r          <= 3'h0;
            has_dest_r          <= 1'b0;
            file_addr_r         <= 13'h0000;
            dest_to_acc_r       <= 1'b0;
            byte_mode_r         <= 1'b0;
            bit_pos_r           <= 4'h0;
            bit_from_reg_r      <= 1'b0;
            literal_r           <= 16'h0000;
        end else begin
            exec_valid_r <= 1'b0;
            if ((state_r == ST_FIRST && fetch_valid && !is_dword(fetch_op)) ||
                (state_r == ST_SECOND && fetch_valid)) begin
                op_code_r           <= dec_op;
                group_r             <= op_group(dec_op);
                base_source_reg_r   <= base_nxt;
                second_source_reg_r <= src_nxt;
                second_mod_r        <= smod_nxt;
                result_dest_reg_r   <= dest_nxt;
                dest_mod_r          <= dmod_nxt;
                has_dest_r          <= has_dest_nxt;
                file_addr_r         <= faddr_nxt;
                dest_to_acc_r       <= acc_nxt;
                byte_mode_r         <= byte_nxt;
                bit_pos_r           <= bpos_nxt;
                bit_from_reg_r      <= bsel_nxt;
                literal_r           <= lit_nxt;
                illegal_r           <= illegal_nxt;
            end
            case (state_r)
                ST_FIRST: begin
                    if (fetch_valid) begin
                        if (is_dword(fetch_op)) begin
                            first_word_r <= fetch_word;
                            state_r      <= ST_SECOND;
                        end else begin
                            exec_valid_r  <= 1'b1;
                            skipped_r     <= 1'b0;
                            double_word_r <= 1'b0;
                            dword_error_r <= 1'b0;
                            // Opcode zero covers a stray second word
                            is_nop_r      <= (fetch_op == `NOP_OP) || illegal_nxt;
                            cycles_r      <= `CYC_ONE + extra;
                            if (is_skip && cond_true) begin
                                cycles_r <= `CYC_TWO;
                                state_r  <= ST_SKIP;
                            end else if (extra != `EXTRA_NONE) begin
                                nop_cnt_r <= extra;
                                state_r   <= ST_NOP;
                            end
                        end
                    end
                end
                ST_SECOND: begin
                    if (fetch_valid) begin
                        exec_valid_r  <= 1'b1;
                        is_nop_r      <= 1'b0;
                        skipped_r     <= 1'b0;
                        double_word_r <= 1'b1;
                        cycles_r      <= `CYC_TWO;
                        literal_r     <= fetch_word[15:0];
                        dword_error_r <= (fetch_word[`OPC_LSB +: `OPC_W] != 8'h00);
                        state_r       <= ST_FIRST;
                    end
                end
                ST_NOP: begin
                    exec_valid_r <= 1'b1;
                    is_nop_r     <= 1'b1;
                    nop_cnt_r    <= nop_cnt_r - 2'h1;
                    if (nop_cnt_r == 2'h1)
                        state_r <= ST_FIRST;
                end
                ST_SKIP: begin
                    if (fetch_valid) begin
                        exec_valid_r <= 1'b1;
                        is_nop_r     <= 1'b1;
                        skipped_r    <= 1'b1;
                        if (is_dword(fetch_op)) begin
                            cycles_r <= `CYC_THREE;
                            state_r  <= ST_SKIP2;
                        end else begin
                            state_r  <= ST_FIRST;
                        end
                    end
                end
                ST_SKIP2: begin
                    if (fetch_valid) begin
                        exec_valid_r <= 1'b1;
                        is_nop_r     <= 1'b1;
                        skipped_r    <= 1'b1;
                        state_r      <= ST_FIRST;
                    end
                end
                default: state_r <= ST_FIRST;
            endcase
        end
    end

endmodule

// file: verif/decode_timing_monitor.sv
// Assertion checker for the instruction word decoder
`timescale 1ns/100ps
`include "instruction_word_decode_timing_defs.vh"
module decode_timing_monitor (
    input wire       clk_sys,
    input wire       rst,
    input wire       fetch_ready,
    input wire       exec_valid_r,
    input wire       is_nop_r,
    input wire       double_word_r,
    input wire [1:0] cycles_r,
    input wire [7:0] op_code_r,
    input wire [3:0] group_r,
    input wire [3:0] base_source_reg_r,
    input wire [3:0] result_dest_reg_r,
    input wire [2:0] dest_mod_r,
    input wire       has_dest_r,
    input wire       bit_from_reg_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Real work only; inserted and skipped cycles carry stale fields
    wire real_exec = exec_valid_r && !is_nop_r;

    a_return_three_cycles: assert property (real_exec && op_code_r[7:1] == 7'h03
        |-> cycles_r == `CYC_THREE && !fetch_ready ##1 exec_valid_r && is_nop_r && !fetch_ready
        ##1 exec_valid_r && is_nop_r && fetch_ready) else $error("return timing wrong");
    a_jump_one_nop: assert property (real_exec && op_code_r == `JUMP_RELATIVE_OP
        |-> cycles_r == `CYC_TWO && !fetch_ready ##1 exec_valid_r && is_nop_r && fetch_ready)
        else $error("jump timing wrong");
    a_double_two_cycles: assert property (real_exec && double_word_r
        |-> cycles_r == `CYC_TWO
        && op_code_r inside {`DW_CALL_OP, `DW_GOTO_OP, `DW_MOVE_OP}) else $error("double wrong");
    // Double-word moves sit in the word group but take two cycles
    a_single_one_cycle: assert property (real_exec && group_r == `GRP_WORD_BYTE
        && !double_word_r |-> cycles_r == `CYC_ONE) else $error("single word not one cycle");
    a_lone_word_nop: assert property (exec_valid_r && !double_word_r
        && op_code_r == `NOP_OP |-> is_nop_r) else $error("lone word not nop");
    a_group_one_hot: assert property (real_exec |-> $onehot(group_r))
        else $error("group not one-hot");
    a_literal_dest_diff: assert property (real_exec && op_code_r[7:4] == `LIT_ARITH_NIB
        |-> has_dest_r == (result_dest_reg_r != base_source_reg_r || dest_mod_r != `MOD_DIRECT))
        else $error("literal destination flag wrong");
    a_bit_reg_sel: assert property (real_exec && op_code_r[7:4] == `BIT_NIB
        |-> bit_from_reg_r == op_code_r[3] && group_r == `GRP_BIT) else $error("bit select wrong");
endmodule

bind instruction_word_decode_timing decode_timing_monitor i_mon (
    .clk_sys(clk_sys), .rst(rst), .fetch_ready(fetch_ready), .exec_valid_r(exec_valid_r),
    .is_nop_r(is_nop_r), .double_word_r(double_word_r), .cycles_r(cycles_r),
    .op_code_r(op_code_r), .group_r(group_r), .base_source_reg_r(base_source_reg_r),
    .result_dest_reg_r(result_dest_reg_r), .dest_mod_r(dest_mod_r), .has_dest_r(has_dest_r),
    .bit_from_reg_r(bit_from_reg_r));

// file: verif/testbench.sv
// Self-checking testbench for the instruction word decoder
`timescale 1ns/100ps
`include "instruction_word_decode_timing_defs.vh"
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        fetch_valid = 1'b0;
    logic [23:0] fetch_word = 24'h00_0000;
    logic        cond_true = 1'b0;
    wire         fetch_ready, exec_valid_r, is_nop_r, skipped_r, illegal_r, double_word_r;
    wire         dword_error_r, has_dest_r, dest_to_acc_r, byte_mode_r, bit_from_reg_r;
    wire  [1:0]  cycles_r;
    wire  [2:0]  second_mod_r, dest_mod_r;
    wire  [3:0]  group_r, base_source_reg_r, second_source_reg_r, result_dest_reg_r, bit_pos_r;
    wire  [7:0]  op_code_r;
    wire  [12:0] file_addr_r;
    wire  [15:0] literal_r;
    int          num_errors = 0;
    int          samples_checked = 0;
    logic [17:0] log_q[$];

    always #25 clk_sys = ~clk_sys;

    instruction_word_decode_timing i_dut (
        .clk_sys(clk_sys), .rst(rst), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
        .cond_true(cond_true), .fetch_ready(fetch_ready), .exec_valid_r(exec_valid_r),
        .is_nop_r(is_nop_r), .skipped_r(skipped_r), .illegal_r(illegal_r),
        .double_word_r(double_word_r), .dword_error_r(dword_error_r), .cycles_r(cycles_r),
        .op_code_r(op_code_r), .group_r(group_r), .base_source_reg_r(base_source_reg_r),
        .second_source_reg_r(second_source_reg_r), .second_mod_r(second_mod_r),
        .result_dest_reg_r(result_dest_reg_r), .dest_mod_r(dest_mod_r), .has_dest_r(has_dest_r),
        .file_addr_r(file_addr_r), .dest_to_acc_r(dest_to_acc_r), .byte_mode_r(byte_mode_r),
        .bit_pos_r(bit_pos_r), .bit_from_reg_r(bit_from_reg_r), .literal_r(literal_r));

    // Log each executed cycle; sampled before this edge's updates land
    always @(posedge clk_sys)
        if (!rst && exec_valid_r)
            log_q.push_back({is_nop_r, skipped_r, double_word_r, dword_error_r, group_r,
                             cycles_r, op_code_r});

    task automatic give_verdict;
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Flags are nop, skipped, double, second word error
    task automatic chk_rec(input logic [3:0] fl, input logic [3:0] grp, input logic [1:0] cyc,
                           input logic [7:0] op, input logic [17:0] m);
        logic [17:0] g = 18'h0_0000;
        chk_val(32'(log_q.size() > 0), 32'h0000_0001);
        if (log_q.size() > 0)
            g = log_q.pop_front();
        chk_val(32'(g & m), 32'({fl, grp, cyc, op} & m));
    endtask

    task automatic issue(input logic [23:0] w, input logic c);
        int n = 0;
        fetch_valid <= 1'b1;
        fetch_word  <= w;
        cond_true   <= c;
        @(posedge clk_sys);
        while (fetch_ready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= 20) begin
            num_errors++;
            $display("ERROR %0t: word never accepted", $time);
            give_verdict;
        end
    endtask

    task automatic idle(input int n);
        fetch_valid <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic t_alu;
        issue(24'h40_0000, 1'b0);
        issue(24'h41_C9A5, 1'b0);
        idle(2);
        chk_rec(4'h0, `GRP_WORD_BYTE, `CYC_ONE, 8'h40, 18'h3_FFFF);
        chk_rec(4'h0, `GRP_WORD_BYTE, `CYC_ONE, 8'h41, 18'h3_FFFF);
        chk_val(32'({base_source_reg_r, second_source_reg_r, second_mod_r, result_dest_reg_r,
            dest_mod_r}), 32'({4'h7, 4'h5, 3'h2, 4'h3, 3'h1}));
    endtask

    // Back to back so every inserted cycle is seen between real ones
    task automatic t_ctrl;
        logic [7:0] ops[8] = '{8'h37, 8'h01, 8'h0A, 8'h0B, 8'h06, 8'h07, 8'h30, 8'h30};
        logic [1:0] cyc[8] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
        foreach (ops[i])
            issue({ops[i], 16'h0000}, i != 7);
        idle(4);
        foreach (ops[i]) begin
            chk_rec(4'h0, `GRP_CONTROL, cyc[i], ops[i], 18'h3_FFFF);
            for (int k = 1; k < cyc[i]; k++)
                chk_rec(4'h8, 4'h0, 2'h0, 8'h00, 18'h3_0000);
        end
        chk_val(log_q.size(), 32'h0000_0000);
    endtask

    task automatic t_double;
        logic [7:0] ops[3] = '{`DW_CALL_OP, `DW_GOTO_OP, `DW_MOVE_OP};
        // A double-word move is still a word operation
        logic [3:0] grp[3] = '{`GRP_CONTROL, `GRP_CONTROL, `GRP_WORD_BYTE};
        foreach (ops[i]) begin
            issue({ops[i], 16'h1111}, 1'b0);
            issue(24'h00_BEEF, 1'b0);
            idle(2);
            chk_rec(4'h2, grp[i], `CYC_TWO, ops[i], 18'h3_FFFF);
            chk_val(32'(literal_r), 32'h0000_BEEF);
        end
        issue(24'h02_0000, 1'b0);
        issue(24'h55_0000, 1'b0);
        issue(24'h00_1234, 1'b0);
        idle(2);
        chk_rec(4'h3, `GRP_CONTROL, `CYC_TWO, 8'h02, 18'h3_FFFF);
        chk_rec(4'h8, 4'h0, 2'h0, 8'h00, 18'h3_0000);
        chk_val(log_q.size(), 32'h0000_0000);
    endtask

    task automatic t_skip;
        issue(24'hA6_0000, 1'b1);
        issue(24'h40_0000, 1'b0);
        issue(24'hA6_0000, 1'b1);
        issue(24'h02_0000, 1'b0);
        issue(24'h00_0000, 1'b0);
        idle(3);
        chk_rec(4'h0, `GRP_BIT, `CYC_TWO, 8'hA6, 18'h3_FFFF);
        chk_rec(4'hC, 4'h0, 2'h0, 8'h00, 18'h3_0000);
        chk_rec(4'h0, `GRP_BIT, `CYC_TWO, 8'hA6, 18'h3_FFFF);
        chk_rec(4'hC, 4'h0, 2'h0, 8'h00, 18'h3_0000);
        chk_rec(4'hC, 4'h0, `CYC_THREE, 8'h00, 18'h3_0300);
        chk_val(log_q.size(), 32'h0000_0000);
    endtask

    task automatic one(input logic [23:0] w);
        issue(w, 1'b0);
        idle(2);
    endtask

    task automatic t_fields;
        one(24'hB2_1ABC);
        chk_val(32'({file_addr_r, dest_to_acc_r, byte_mode_r}), 32'({13'h1ABC, 2'h2}));
        one(24'hB1_0005);
        chk_val(32'({file_addr_r, dest_to_acc_r, byte_mode_r}), 32'({13'h0005, 2'h1}));
        one(24'hA8_7340);
        chk_val(32'({bit_from_reg_r, base_source_reg_r}), 32'({1'h1, 4'h3}));
        one(24'hA0_C200);
        chk_val(32'({bit_from_reg_r, bit_pos_r}), 32'({1'h0, 4'hC}));
        // Literal move form: literal spans opcode nibble and word
        one(24'h7A_BCD5);
        chk_val(32'({has_dest_r, group_r, result_dest_reg_r, literal_r}),
            32'({1'h1, 4'h4, 4'h5, 16'hABCD}));
        // Unused opcode range is flagged and lands in control group
        one(24'h9F_0000);
        chk_val(32'({illegal_r, group_r}), 32'({1'h1, 4'h8}));
        one(24'h64_3313);
        chk_val(32'({illegal_r, has_dest_r, group_r, literal_r}),
            32'({1'h0, 1'h0, 4'h4, 16'h0013}));
        one(24'h64_3553);
        chk_val(32'({has_dest_r, group_r, literal_r}), 32'({1'h1, 4'h4, 16'h0013}));
        log_q.delete();
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_alu;
        t_ctrl;
        t_double;
        t_skip;
        t_fields;
        give_verdict;
    end
endmodule
